// file: rtl/ddr2_link_pkg.sv
package ddr2_link_pkg;

   // Link geometry
   localparam int BANKS     = 8;
   localparam int BA_W      = 3;
   localparam int ADDR_W    = 14;
   localparam int COL_W     = 10;
   localparam int DQ_W      = 16;
   localparam int LANES     = 2;
   localparam int LANE_W    = 8;
   localparam int BURST_LEN = 4;
   localparam int BEAT_W    = 3;
   localparam int WRAP_W    = 2;

   // Address bit positions
   localparam int AP_BIT       = 10;
   localparam int DQSN_DIS_BIT = 10;
   localparam int RTT0_BIT     = 2;
   localparam int RTT1_BIT     = 6;

   // Mode register select on the bank lines
   localparam logic [BA_W-1:0] EMR1_SEL = 3'h1;

   // Reset values of the extended mode bits
   localparam logic DQSN_DIS_RST = 1'b0;
   localparam logic ODT_EN_RST   = 1'b0;

   // Link clock cycles from read command edge to read wait end
   localparam int RD_LAT_CK = 2;

   typedef enum logic [2:0] {
      CMD_NOP,
      CMD_ACT,
      CMD_RD,
      CMD_WR,
      CMD_PRE,
      CMD_REF,
      CMD_MRS
   } cmd_t;

   // Pin levels are {ras_n, cas_n, we_n}
   function automatic cmd_t cmd_decode(input logic [2:0] rcw);
      cmd_t c;
      c = CMD_NOP;
      unique case (rcw)
         3'h3:    c = CMD_ACT;
         3'h5:    c = CMD_RD;
         3'h4:    c = CMD_WR;
         3'h2:    c = CMD_PRE;
         3'h1:    c = CMD_REF;
         3'h0:    c = CMD_MRS;
         default: c = CMD_NOP;
      endcase
      return c;
   endfunction

   function automatic logic [2:0] cmd_encode(input cmd_t c);
      logic [2:0] rcw;
      rcw = 3'h7;
      unique case (c)
         CMD_ACT: rcw = 3'h3;
         CMD_RD:  rcw = 3'h5;
         CMD_WR:  rcw = 3'h4;
         CMD_PRE: rcw = 3'h2;
         CMD_REF: rcw = 3'h1;
         CMD_MRS: rcw = 3'h0;
         default: rcw = 3'h7;
      endcase
      return rcw;
   endfunction

endpackage

// file: rtl/ddr2_link_if.sv
`timescale 1ns/1ps
interface ddr2_link_if;
   import ddr2_link_pkg::*;

   logic                ck;
   logic                cs_n;
   logic                ras_n;
   logic                cas_n;
   logic                we_n;
   logic [BA_W-1:0]     ba;
   logic [ADDR_W-1:0]   a;
   logic                odt;
   logic [LANES-1:0]    dm;
   logic [DQ_W-1:0]     dq_ctl;
   logic [LANES-1:0]    dq_ctl_oe;
   logic [DQ_W-1:0]     dq_mem;
   logic [LANES-1:0]    dq_mem_oe;
   logic [LANES-1:0]    dqs_ctl;
   logic [LANES-1:0]    dqs_ctl_oe;
   logic [LANES-1:0]    dqs_n_ctl;
   logic [LANES-1:0]    dqs_n_ctl_oe;
   logic [LANES-1:0]    dqs_mem;
   logic [LANES-1:0]    dqs_mem_oe;
   logic [LANES-1:0]    dqs_n_mem;
   logic [LANES-1:0]    dqs_n_mem_oe;
   wire  [DQ_W-1:0]     dq;
   wire  [LANES-1:0]    dqs;
   wire  [LANES-1:0]    dqs_n;

   // Undriven lanes resolve to zero
   for (genvar l = 0; l < LANES; l++)
   begin : g_lane
      assign dq[l*LANE_W +: LANE_W] = dq_mem_oe[l] ? dq_mem[l*LANE_W +: LANE_W] :
                                      dq_ctl_oe[l] ? dq_ctl[l*LANE_W +: LANE_W] : '0;
      assign dqs[l]   = dqs_mem_oe[l] ? dqs_mem[l] : (dqs_ctl_oe[l] & dqs_ctl[l]);
      assign dqs_n[l] = dqs_n_mem_oe[l] ? dqs_n_mem[l] : (dqs_n_ctl_oe[l] & dqs_n_ctl[l]);
   end

   modport mem (
      input  ck, cs_n, ras_n, cas_n, we_n, ba, a, odt, dm, dq, dqs, dqs_n,
      output dq_mem, dq_mem_oe, dqs_mem, dqs_mem_oe, dqs_n_mem, dqs_n_mem_oe
   );

   modport ctl (
      output ck, cs_n, ras_n, cas_n, we_n, ba, a, odt, dm,
      output dq_ctl, dq_ctl_oe, dqs_ctl, dqs_ctl_oe, dqs_n_ctl, dqs_n_ctl_oe,
      input  dq, dqs, dqs_n
   );

endinterface

// file: rtl/level_sync.sv
`timescale 1ns/1ps
module level_sync #(
   parameter int WIDTH = 1
)(
   // Clock and reset
   input  wire logic             clock_in,
   input  wire logic             rstn_in,
   input  wire logic             ce_in,
   // Data
   input  wire logic [WIDTH-1:0] d_in,
   output logic      [WIDTH-1:0] q_out
);

   logic [WIDTH-1:0] meta_q;

   if (WIDTH < 1)
   begin : g_chk
      $error("level_sync WIDTH must be at least 1");
   end

   // First stage feeds only the second stage
   always_ff @(posedge clock_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         meta_q <= '0;
         q_out  <= '0;
      end
      else if (ce_in)
      begin
         meta_q <= d_in;
         q_out  <= meta_q;
      end
   end

endmodule

// file: rtl/ddr2_mem_end.sv
// Functional notes
// R1: Chip select high ignores commands, bursts finish.
// R2: RAS, CAS, WE at rising edge pick command.
// R3: Activate takes all fourteen address bits as row.
// R4: Read or write takes low ten bits as column.
// R5: Bit ten on read/write precharges bank after burst.
// R6: Precharge with bit ten closes all eight banks.
// R7: Bank lines select the targeted bank.
// R8: Sixteen-bit data bus, device drives reads.
// R9: Read strobe edge-aligned, write strobe centred.
// R10: Lower strobe times low byte, upper high byte; here writes use the link clock, reads the lower strobe for both bytes.
// R11: Extended mode bit disables complementary strobes.
// R12: That disable bit is address bit ten.
// R13: Masked write beats are not stored.
// R14: Mask sampled per beat on both strobe edges; here once per beat on the rising link clock.
// R15: Lower mask gates low byte, upper high byte.
// R16: Termination input turns on all data-side termination.
// R17: Termination disabled in mode register ignores input.
// R18: Non-data inputs sampled on rising link clock.
// R19: Command encodings follow standard DDR2 table.
`timescale 1ns/1ps
module ddr2_mem_end
   import ddr2_link_pkg::*;
#(
   parameter int MEM_ROW_W = 1,
   parameter int MEM_COL_W = 4,
   parameter int RD_LAT    = RD_LAT_CK
)(
   // System side
   input  wire logic             clock_in,
   input  wire logic             rstn_in,
   input  wire logic             ce_in,
   // Link
   ddr2_link_if.mem              link,
   // Status, on clock_in
   output logic                  term_on_out,
   output logic                  strobe_diff_out,
   output logic                  busy_out,
   output logic [BANKS-1:0]      banks_open_out
);

   localparam int IDX_W = BA_W + MEM_ROW_W + MEM_COL_W;
   localparam int DEPTH = 1 << IDX_W;
   localparam int LAT_W = 4;

   if (MEM_COL_W <= WRAP_W || MEM_COL_W > COL_W || MEM_ROW_W < 1 || MEM_ROW_W > ADDR_W ||
       RD_LAT < 1 || RD_LAT > 15)
   begin : g_chk
      $error("ddr2_mem_end parameters out of range");
   end

   typedef enum logic [1:0] {
      D_IDLE,
      D_WR,
      D_RDWAIT,
      D_RD
   } dstate_t;

   dstate_t                state_q;
   logic [BEAT_W-1:0]      beat_q;
   logic [LAT_W-1:0]       lat_q;
   logic [BA_W-1:0]        bank_q;
   logic [COL_W-1:0]       col_q;
   logic                   ap_q;
   logic [ADDR_W-1:0]      row_q [BANKS];
   logic [BANKS-1:0]       open_q;
   logic [BANKS-1:0]       open_d;
   logic                   dqsn_dis_q;
   logic                   odt_en_q;
   logic                   term_q;
   logic [DQ_W-1:0]        mem_q [DEPTH];
   logic [DQ_W-1:0]        dq_q;
   logic [LANES-1:0]       dq_oe_q;
   logic [LANES-1:0]       dqs_q;
   logic [LANES-1:0]       dqs_oe_q;
   logic [LANES-1:0]       dqs_n_q;
   logic [LANES-1:0]       dqs_n_oe_q;
   logic                   ce_ck;
   logic [BANKS+2:0]       stat_s;

   // Word index: bank, low row bits, column with burst wrap
   function automatic logic [IDX_W-1:0] mem_idx(input logic [BA_W-1:0]    b,
                                                input logic [ADDR_W-1:0]  r,
                                                input logic [COL_W-1:0]   c,
                                                input logic [BEAT_W-1:0]  beat);
      logic [WRAP_W-1:0] wrap;
      wrap = c[WRAP_W-1:0] + beat[WRAP_W-1:0];
      return {b, r[MEM_ROW_W-1:0], c[MEM_COL_W-1:WRAP_W], wrap};
   endfunction

   // Link-side state freezes with the enable, brought over from clock_in
   level_sync #(.WIDTH(1)) u_ce_sync (
      .clock_in (link.ck),
      .rstn_in  (rstn_in),
      .ce_in    (1'b1),
      .d_in     (ce_in),
      .q_out    (ce_ck)
   );

   wire cmd_t                 cmd        = link.cs_n ? CMD_NOP :
                                           cmd_decode({link.ras_n, link.cas_n, link.we_n}); // [R1] [R2] [R19]
   wire                       ap_sel     = link.a[AP_BIT];
   wire [COL_W-1:0]           col_in     = link.a[COL_W-1:0]; // [R4]
   wire                       burst_last = (beat_q == BEAT_W'(BURST_LEN - 1));
   wire                       in_burst   = (state_q == D_WR) || (state_q == D_RD);
   wire                       burst_end  = in_burst && burst_last;
   wire                       rd_drive   = (state_q == D_RD);
   wire [IDX_W-1:0]           cur_idx    = mem_idx(bank_q, row_q[bank_q], col_q, beat_q);
   wire [DQ_W-1:0]            rd_word    = mem_q[cur_idx];
   wire [LANES-1:0]           lane_we    = {LANES{state_q == D_WR}} & ~link.dm; // [R13] [R15]
   wire                       emr1_wr    = (cmd == CMD_MRS) && (link.ba == EMR1_SEL);
   wire [LANES-1:0]           dqs_nxt    = {LANES{rd_drive & ~beat_q[0]}};

   always_comb
   begin
      open_d = open_q;
      if (burst_end && ap_q)
         open_d[bank_q] = 1'b0; // [R5]
      unique case (cmd)
         CMD_ACT: open_d[link.ba] = 1'b1; // [R7]
         CMD_PRE:
         begin
            if (ap_sel)
               open_d = '0; // [R6]
            else
               open_d[link.ba] = 1'b0; // [R6] [R7]
         end
         default: ;
      endcase
   end

   always_ff @(posedge link.ck or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         open_q <= '0;
         row_q  <= '{default: '0};
      end
      else if (ce_ck)
      begin
         open_q <= open_d;
         if (cmd == CMD_ACT)
         begin
            row_q[link.ba] <= link.a; // [R3] [R18]
         end
      end
   end

   // A new read or write is only taken between bursts
   always_ff @(posedge link.ck or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         state_q <= D_IDLE;
         beat_q  <= '0;
         lat_q   <= '0;
         bank_q  <= '0;
         col_q   <= '0;
         ap_q    <= 1'b0;
      end
      else if (ce_ck)
      begin
         unique case (state_q)
            D_IDLE:
            begin
               if (cmd == CMD_RD || cmd == CMD_WR)
               begin
                  bank_q  <= link.ba; // [R7]
                  col_q   <= col_in; // [R4]
                  ap_q    <= ap_sel; // [R5]
                  beat_q  <= '0;
                  lat_q   <= LAT_W'(RD_LAT - 1);
                  state_q <= (cmd == CMD_WR) ? D_WR : D_RDWAIT;
               end
            end
            D_RDWAIT:
            begin
               if (lat_q == '0)
                  state_q <= D_RD;
               else
                  lat_q <= lat_q - 1'b1;
            end
            D_WR, D_RD:
            begin
               beat_q <= beat_q + 1'b1;
               if (burst_last)
               begin
                  state_q <= D_IDLE;
               end
            end
         endcase
      end
   end

   // One beat per link cycle; the strobe toggles once per beat
   always_ff @(posedge link.ck)
   begin
      if (ce_ck)
      begin
         for (int l = 0; l < LANES; l++)
         begin
            if (lane_we[l])
            begin
               mem_q[cur_idx][l*LANE_W +: LANE_W] <= link.dq[l*LANE_W +: LANE_W]; // [R14] [R10]
            end
         end
      end
   end

   always_ff @(posedge link.ck or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         dqsn_dis_q <= DQSN_DIS_RST;
         odt_en_q   <= ODT_EN_RST;
         term_q     <= 1'b0;
      end
      else if (ce_ck)
      begin
         if (emr1_wr)
         begin
            dqsn_dis_q <= link.a[DQSN_DIS_BIT]; // [R11] [R12]
            odt_en_q   <= link.a[RTT0_BIT] | link.a[RTT1_BIT];
         end
         term_q <= link.odt & odt_en_q; // [R16] [R17] [R18]
      end
   end

   // Data and strobe change on the same edge for reads
   always_ff @(posedge link.ck or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         dq_q       <= '0;
         dq_oe_q    <= '0;
         dqs_q      <= '0;
         dqs_oe_q   <= '0;
         dqs_n_q    <= '1;
         dqs_n_oe_q <= '0;
      end
      else if (ce_ck)
      begin
         dq_q       <= rd_word; // [R8]
         dq_oe_q    <= {LANES{rd_drive}}; // [R8] [R10]
         dqs_q      <= dqs_nxt; // [R9] [R10]
         dqs_oe_q   <= {LANES{rd_drive}};
         dqs_n_q    <= ~dqs_nxt;
         dqs_n_oe_q <= {LANES{rd_drive & ~dqsn_dis_q}}; // [R11]
      end
   end

   assign link.dq_mem       = dq_q;
   assign link.dq_mem_oe    = dq_oe_q;
   assign link.dqs_mem      = dqs_q;
   assign link.dqs_mem_oe   = dqs_oe_q;
   assign link.dqs_n_mem    = dqs_n_q;
   assign link.dqs_n_mem_oe = dqs_n_oe_q;

   level_sync #(.WIDTH(BANKS + 3)) u_stat_sync (
      .clock_in (clock_in),
      .rstn_in  (rstn_in),
      .ce_in    (ce_in),
      .d_in     ({term_q, ~dqsn_dis_q, state_q != D_IDLE, open_q}),
      .q_out    (stat_s)
   );

   assign term_on_out     = stat_s[BANKS+2];
   assign strobe_diff_out = stat_s[BANKS+1];
   assign busy_out        = stat_s[BANKS];
   assign banks_open_out  = stat_s[BANKS-1:0];

endmodule

// file: rtl/ddr2_ctl_end.sv
`timescale 1ns/1ps
module ddr2_ctl_end
   import ddr2_link_pkg::*;
(
   // System side
   input  wire logic                          clock_in,
   input  wire logic                          rstn_in,
   input  wire logic                          ce_in,
   // Request
   input  wire logic                          req_valid_in,
   input  wire cmd_t                          req_cmd_in,
   input  wire logic [BA_W-1:0]               req_ba_in,
   input  wire logic [ADDR_W-1:0]             req_addr_in,
   input  wire logic [DQ_W*BURST_LEN-1:0]     req_wdata_in,
   input  wire logic [LANES*BURST_LEN-1:0]    req_wmask_in,
   input  wire logic                          odt_in,
   input  wire logic                          dqsn_en_in,
   output logic                               req_ready_out,
   // Read answer
   output logic                               rd_valid_out,
   output logic [DQ_W*BURST_LEN-1:0]          rd_data_out,
   // Link
   ddr2_link_if.ctl                           link
);

   typedef enum logic [1:0] {
      H_IDLE,
      H_WR,
      H_RD
   } hstate_t;

   hstate_t                      state_q;
   logic [BEAT_W-1:0]            beat_q;
   logic                         ck_q;
   logic                         cs_n_q;
   logic [2:0]                   rcw_q;
   logic [BA_W-1:0]              ba_q;
   logic [ADDR_W-1:0]            a_q;
   logic                         odt_q;
   logic [LANES-1:0]             dm_q;
   logic [DQ_W-1:0]              dq_q;
   logic                         drv_q;
   logic                         dqs_q;
   logic                         dqsn_q;
   logic [DQ_W*BURST_LEN-1:0]    wdata_q;
   logic [LANES*BURST_LEN-1:0]   wmask_q;
   logic                         strobe_prev_q;
   logic [DQ_W:0]                rd_s;

   // Read pins pass two flops before use
   level_sync #(.WIDTH(DQ_W + 1)) u_rd_sync (
      .clock_in (clock_in),
      .rstn_in  (rstn_in),
      .ce_in    (ce_in),
      .d_in     ({link.dqs[0], link.dq}),
      .q_out    (rd_s)
   );

   // Pins change at the link clock fall, so the device sees them settled at the rise
   wire tick     = ck_q;
   wire new_beat = tick && (state_q == H_RD) && (rd_s[DQ_W] != strobe_prev_q);
   wire wr_done  = (beat_q == BEAT_W'(BURST_LEN));
   wire rd_last  = (beat_q == BEAT_W'(BURST_LEN - 1));

   always_ff @(posedge clock_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         ck_q <= 1'b0;
      end
      else if (ce_in)
      begin
         ck_q <= ~ck_q;
      end
   end

   always_ff @(posedge clock_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         state_q       <= H_IDLE;
         beat_q        <= '0;
         cs_n_q        <= 1'b1;
         rcw_q         <= 3'h7;
         ba_q          <= '0;
         a_q           <= '0;
         odt_q         <= 1'b0;
         wdata_q       <= '0;
         wmask_q       <= '0;
         req_ready_out <= 1'b0;
         rd_valid_out  <= 1'b0;
         rd_data_out   <= '0;
         strobe_prev_q <= 1'b0;
      end
      else if (ce_in)
      begin
         req_ready_out <= 1'b0;
         rd_valid_out  <= 1'b0;
         if (tick)
         begin
            // Command pins keep their last level while deselected; the device must ignore them
            cs_n_q        <= 1'b1;
            odt_q         <= odt_in;
            strobe_prev_q <= rd_s[DQ_W];
            unique case (state_q)
               H_IDLE:
               begin
                  if (req_valid_in)
                  begin
                     cs_n_q        <= 1'b0; // [R1]
                     rcw_q         <= cmd_encode(req_cmd_in); // [R2] [R19]
                     ba_q          <= req_ba_in; // [R7]
                     a_q           <= req_addr_in; // [R3] [R4]
                     wdata_q       <= req_wdata_in;
                     wmask_q       <= req_wmask_in;
                     beat_q        <= '0;
                     req_ready_out <= 1'b1;
                     if (req_cmd_in == CMD_WR)
                     begin
                        state_q <= H_WR;
                     end
                     else if (req_cmd_in == CMD_RD)
                     begin
                        state_q <= H_RD;
                     end
                  end
               end
               H_WR:
               begin
                  beat_q <= beat_q + 1'b1;
                  if (wr_done)
                  begin
                     state_q <= H_IDLE;
                  end
               end
               H_RD:
               begin
                  if (new_beat)
                  begin
                     rd_data_out[beat_q*DQ_W +: DQ_W] <= rd_s[DQ_W-1:0]; // [R8]
                     beat_q <= beat_q + 1'b1;
                     if (rd_last)
                     begin
                        rd_valid_out <= 1'b1;
                        state_q      <= H_IDLE;
                     end
                  end
               end
            endcase
         end
      end
   end

   // Write data moves at the fall, the strobe at the rise: centred in each beat
   always_ff @(posedge clock_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         dq_q   <= '0;
         dm_q   <= '0;
         drv_q  <= 1'b0;
         dqs_q  <= 1'b0;
         dqsn_q <= 1'b0;
      end
      else if (ce_in)
      begin
         if (tick)
         begin
            drv_q  <= (state_q == H_WR) && !wr_done; // [R8]
            dq_q   <= wdata_q[beat_q[WRAP_W-1:0]*DQ_W +: DQ_W];
            dm_q   <= (state_q == H_WR && !wr_done) ?
                      wmask_q[beat_q[WRAP_W-1:0]*LANES +: LANES] : '0; // [R13] [R14] [R15]
            dqsn_q <= dqsn_en_in; // [R11]
            if (!drv_q)
            begin
               dqs_q <= 1'b0;
            end
         end
         else if (drv_q)
         begin
            dqs_q <= ~dqs_q; // [R9]
         end
      end
   end

   assign link.ck           = ck_q;
   assign link.cs_n         = cs_n_q;
   assign link.ras_n        = rcw_q[2];
   assign link.cas_n        = rcw_q[1];
   assign link.we_n         = rcw_q[0];
   assign link.ba           = ba_q;
   assign link.a            = a_q;
   assign link.odt          = odt_q;
   assign link.dm           = dm_q;
   assign link.dq_ctl       = dq_q;
   assign link.dq_ctl_oe    = {LANES{drv_q}}; // [R10]
   assign link.dqs_ctl      = {LANES{dqs_q}}; // [R10]
   assign link.dqs_ctl_oe   = {LANES{drv_q}};
   assign link.dqs_n_ctl    = {LANES{~dqs_q}};
   assign link.dqs_n_ctl_oe = {LANES{drv_q & dqsn_q}};

endmodule

// file: tb/ddr2_link_monitor.sv
`timescale 1ns/1ps
module ddr2_link_monitor
   import ddr2_link_pkg::*;
(
   // Link clock and reset
   input  wire logic             ck,
   input  wire logic             rstn_in,
   // Link signals
   input  wire logic             cs_n,
   input  wire logic             ras_n,
   input  wire logic             cas_n,
   input  wire logic             we_n,
   input  wire logic [LANES-1:0] dm,
   input  wire logic [LANES-1:0] dq_ctl_oe,
   input  wire logic [LANES-1:0] dq_mem_oe,
   input  wire logic [LANES-1:0] dqs_mem_oe,
   input  wire logic [LANES-1:0] dqs_n_mem_oe,
   input  wire logic [LANES-1:0] dqs,
   input  wire logic [LANES-1:0] dqs_n
);
   default clocking @(posedge ck); endclocking
   default disable iff (!rstn_in);

   wire wr_cmd = !cs_n && {ras_n, cas_n, we_n} == 3'h4;
   wire rd_cmd = !cs_n && {ras_n, cas_n, we_n} == 3'h5;

   // Strobe rises land mid-beat on writes, with the beat on reads
   sequence s_wr;
      (dq_ctl_oe == 2'h3 && dqs == 2'h0) ##1 dqs == 2'h3 ##1 dqs == 2'h0
      ##1 dqs == 2'h3 ##1 dq_ctl_oe == 2'h0;
   endsequence
   sequence s_rd;
      ##4 (dq_mem_oe == 2'h3 && dqs == 2'h3) ##1 dqs == 2'h0 ##1 dqs == 2'h3
      ##1 dqs == 2'h0 ##1 dq_mem_oe == 2'h0;
   endsequence

   a_wr_burst_shape: assert property (wr_cmd |=> s_wr)
      else $error("write burst strobe sequence wrong");
   a_rd_burst_shape: assert property (rd_cmd |-> s_rd)
      else $error("read burst strobe sequence wrong");
   a_dq_no_clash: assert property ((dq_mem_oe & dq_ctl_oe) == 2'h0)
      else $error("both ends drive data");
   a_lane_strobe_pair: assert property (dq_mem_oe != 2'h0 |-> dqs_mem_oe == dq_mem_oe)
      else $error("read strobe lanes differ from data lanes");
   a_strobe_compl: assert property (dqs_n_mem_oe == 2'h3 |-> dqs_n == ~dqs)
      else $error("complement strobe not inverse");
   a_mask_idle: assert property (dq_ctl_oe == 2'h0 |-> dm == 2'h0)
      else $error("mask active outside write");
   a_rd_ctl_quiet: assert property (rd_cmd |-> dq_ctl_oe == 2'h0 [*8])
      else $error("controller drives data in read");
   a_wr_mem_quiet: assert property (wr_cmd |-> dq_mem_oe == 2'h0 [*6])
      else $error("device drives data in write");
endmodule

// file: tb/ddr2_sdram_pin_interface_bench.sv
`timescale 1ns/1ps
module ddr2_sdram_pin_interface_bench;
   import ddr2_link_pkg::*;
   logic              clock_in = 1'h0;
   logic              rstn_in = 1'h0;
   logic              req_valid = 1'h0;
   cmd_t              req_cmd = CMD_NOP;
   logic [BA_W-1:0]   req_ba = 3'h0;
   logic [ADDR_W-1:0] req_addr = 14'h0;
   logic [63:0]       req_wdata = 64'h0;
   logic [7:0]        req_wmask = 8'h0;
   logic              odt_lvl = 1'h0;
   logic              dqsn_en = 1'h0;
   logic              ce = 1'h1;
   logic              req_ready;
   logic              rd_valid;
   logic [63:0]       rd_data;
   logic              term_on;
   logic              strobe_diff;
   logic              busy;
   logic [BANKS-1:0]  banks_open;
   logic [BANKS-1:0]  open_m = 8'h0;
   logic [15:0]       mem [256];
   int                num_errors = 0;
   int                total_checks = 0;

   ddr2_link_if link ();
   ddr2_ctl_end ddr2_ctl_end_inst (.clock_in(clock_in), .rstn_in(rstn_in), .ce_in(ce),
      .req_valid_in(req_valid), .req_cmd_in(req_cmd), .req_ba_in(req_ba),
      .req_addr_in(req_addr), .req_wdata_in(req_wdata), .req_wmask_in(req_wmask),
      .odt_in(odt_lvl), .dqsn_en_in(dqsn_en), .req_ready_out(req_ready),
      .rd_valid_out(rd_valid), .rd_data_out(rd_data), .link(link));
   ddr2_mem_end ddr2_mem_end_inst (.clock_in(clock_in), .rstn_in(rstn_in), .ce_in(ce),
      .link(link), .term_on_out(term_on), .strobe_diff_out(strobe_diff), .busy_out(busy),
      .banks_open_out(banks_open));
   ddr2_link_monitor monitor_inst (.ck(link.ck), .rstn_in(rstn_in), .cs_n(link.cs_n),
      .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n), .dm(link.dm),
      .dq_ctl_oe(link.dq_ctl_oe), .dq_mem_oe(link.dq_mem_oe), .dqs_mem_oe(link.dqs_mem_oe),
      .dqs_n_mem_oe(link.dqs_n_mem_oe), .dqs(link.dqs), .dqs_n(link.dqs_n));

   initial
      forever #12.5 clock_in = ~clock_in;

   task automatic report_and_stop;
      if (num_errors == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Bounded wait on the request handshake or on read data
   task automatic wait_hi(input bit rd);
      int n;
      n = 0;
      while ((rd ? rd_valid : req_ready) !== 1'h1 && n < 300)
      begin
         @(posedge clock_in);
         n++;
      end
      if (n >= 300)
      begin
         num_errors++;
         report_and_stop();
      end
   endtask

   task automatic req(input cmd_t c, input logic [2:0] b, input logic [13:0] a);
      @(posedge clock_in);
      req_cmd <= c;
      req_ba <= b;
      req_addr <= a;
      req_valid <= 1'h1;
      @(posedge clock_in);
      wait_hi(1'b0);
      req_valid <= 1'h0;
   endtask

   // Status crosses a two-flop synchroniser, so give it time to land
   task automatic settle;
      repeat (16) @(posedge clock_in);
      chk(64'(busy), 64'h0);
      chk(64'(banks_open), 64'(open_m));
   endtask

   initial
   begin
      int b;
      int k;
      logic [13:0] row;
      logic [13:0] col;
      logic [13:0] col2;
      logic [63:0] exp;
      logic [7:0]  idx;
      void'($urandom(13341));
      repeat (8) @(posedge clock_in);
      rstn_in <= 1'h1;
      repeat (8) @(posedge clock_in);
      for (k = 7; k >= 0; k--)
      begin
         odt_lvl <= k[0];
         req(CMD_MRS, EMR1_SEL, {3'h0, k[0], 3'h0, k[1] & k[2], 3'h0, k[1] & !k[2], 2'h0});
         settle();
         chk(64'(strobe_diff), 64'(!k[0]));
         chk(64'(term_on), 64'(k[1] & k[0]));
      end
      dqsn_en <= 1'h1;
      req(CMD_REF, 3'h0, 14'h0);
      req(CMD_NOP, 3'h0, 14'h0);
      for (k = 0; k < 16; k++)
      begin
         b = k % 8;
         row = 14'($urandom);
         col = 14'($urandom) & 14'h3ff;
         col2 = {col[13:2], 2'($urandom)};
         req(CMD_ACT, b[2:0], row);
         open_m[b] = 1'h1;
         // Unmasked first pass, so masked bytes later compare against known data
         for (int p = 0; p < 2; p++)
         begin
            req_wdata <= {$urandom, $urandom};
            req_wmask <= (p == 0) ? 8'h0 : 8'($urandom);
            req(CMD_WR, b[2:0], col);
            // Freeze both ends in the burst; changed at a link fall to spare the device sync
            @(posedge clock_in);
            ce <= 1'h0;
            repeat (3) @(posedge clock_in);
            ce <= 1'h1;
            for (int i = 0; i < 4; i++)
            begin
               idx = {b[2:0], row[0], col[3:2], 2'(col[1:0] + i)};
               if (!req_wmask[2*i])
                  mem[idx][7:0] = req_wdata[16*i +: 8];
               if (!req_wmask[2*i+1])
                  mem[idx][15:8] = req_wdata[16*i+8 +: 8];
            end
         end
         req(CMD_RD, b[2:0], col2 | {3'h0, k[3], 10'h0});
         wait_hi(1'b1);
         for (int i = 0; i < 4; i++)
            exp[16*i +: 16] = mem[{b[2:0], row[0], col2[3:2], 2'(col2[1:0] + i)}];
         chk(rd_data, exp);
         if (k[3])
            open_m[b] = 1'h0;
         settle();
      end
      req(CMD_ACT, 3'h2, 14'h0);
      req(CMD_ACT, 3'h5, 14'h0);
      req(CMD_PRE, 3'h2, 14'h0);
      open_m = 8'h20;
      settle();
      req(CMD_PRE, 3'h2, 14'h400);
      open_m = 8'h0;
      settle();
      report_and_stop();
   end
endmodule
